// >>> rtl/cis_map.svh
// register offsets, field positions, reset values and cycle counts
// Function
// - core clock straight from source, no divider
// - arbitration runs alongside the executing instruction
// - register operand write-back finishes in one cycle
// - distinct vectors; take needs source and global enable
// - lowest vector wins; reset highest, then request zero
// - table select moves vectors to boot start
// - reset vector fuse starts at boot start
// - boot lock bits suppress interrupts by pc
// - accepting clears global enable
// - return sets global enable; nesting when set
// - vectoring clears flag with pc redirect
// - writing one clears flag, zero keeps
// - masked flags stay pending until served
// - level sources request only while present
// - one instruction runs after return first
// - status flags never saved or restored
// - clear global enable acts at once
// - instruction after set runs before interrupts
// - entry takes four cycles, pushes pc
// - jump at vector takes three cycles
// - multi-cycle instruction completes before entry
// - wake from sleep adds four entry cycles
// - return takes four cycles, pops, sets enable
// - global enable is status bit seven
// - entry push lowers stack pointer by two
`ifndef CIS_MAP_SVH
`define CIS_MAP_SVH
`define CIS_OFS_STATUS 8'h00
`define CIS_OFS_ENABLE 8'h04
`define CIS_OFS_FLAGS 8'h08
`define CIS_OFS_CONTROL 8'h0C
`define CIS_OFS_STACK 8'h10
`define CIS_OFS_SEQ 8'h14
`define CIS_GIE_BIT 7
`define CIS_VTS_BIT 0
`define CIS_STATUS_RST 8'h00
`define CIS_SP_RST 16'h0000
`define CIS_ENTRY_CYC 4'h4
`define CIS_WAKE_CYC 4'h4
`define CIS_JUMP_CYC 4'h3
`define CIS_RETURN_CYC 4'h4
`define CIS_PC_BYTES 16'h0002
`define CIS_SP_STEP 16'h0001
`define CIS_CNT_ONE 4'h1
`define CIS_CNT_TWO 4'h2
`define CIS_CNT_THREE 4'h3
`endif

// >>> rtl/cis_pkg.sv
// types shared by the interrupt sequencer modules
package cis_pkg;
  // sequencer states
  typedef enum logic [2:0]
  {
    CIS_RSTV = 3'b000,
    CIS_IDLE = 3'b001,
    CIS_ENTRY = 3'b010,
    CIS_JUMP = 3'b011,
    CIS_RETURN = 3'b100
  } cis_state_e;
endpackage

// >>> rtl/cis_req_if.sv
// request bundle between flag bank, arbiter and sequencer
`timescale 1ns/10ps
interface cis_req_if #(parameter int SRC = 8);
  localparam int IDX_W = (SRC > 1) ? $clog2(SRC) : 1;
  logic [SRC-1:0] pending; // flag or live level per source
  logic [SRC-1:0] enable; // per-source enables
  logic [SRC-1:0] clearMask; // software write-one-to-clear
  logic [SRC-1:0] ackMask; // hardware clear at vectoring
  logic anyReq; // some enabled source pending
  logic [IDX_W-1:0] winner; // lowest pending enabled index
  modport flags (input clearMask, input ackMask, output pending);
  modport arb (input pending, input enable, output anyReq, output winner);
  modport core (output clearMask, output ackMask, output enable,
    input pending, input anyReq, input winner);
endinterface

// >>> rtl/cis_flags.sv
// per-source pending flags, flag-type or level-type
`timescale 1ns/10ps
module cis_flags #(
  parameter int SRC = 8,
  parameter logic [SRC-1:0] LEVEL_MASK = '0
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [SRC-1:0] srcEvent,
  input wire logic [SRC-1:0] srcLevel,
  cis_req_if.flags ifc
);
  logic [SRC-1:0] flag; // sticky event flags
  logic [SRC-1:0] next_flag; // next flag value per source
  genvar i;
  generate
    for (i = 0; i < SRC; i++)
    begin : g_src
      // set beats clear so a same-cycle event is kept
      assign next_flag[i] = srcEvent[i] |
        (flag[i] & ~ifc.clearMask[i] & ~ifc.ackMask[i]);
      // level sources bypass the flag entirely
      assign ifc.pending[i] = LEVEL_MASK[i] ? srcLevel[i] : flag[i];
    end
  endgenerate
  // all flags update together from one process
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      flag <= '0;
    else
      flag <= next_flag;
  end
endmodule

// >>> rtl/cis_arbiter.sv
// fixed priority pick, lowest index means lowest vector
`timescale 1ns/10ps
module cis_arbiter #(
  parameter int SRC = 8
)
(
  cis_req_if.arb ifc
);
  localparam int IDX_W = (SRC > 1) ? $clog2(SRC) : 1;
  // lowest set bit index
  function automatic logic [IDX_W-1:0] pickLowest(input logic [SRC-1:0] v);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = SRC - 1; i >= 0; i--)
      if (v[i])
        idx = IDX_W'(i);
    return idx;
  endfunction
  wire logic [SRC-1:0] live = ifc.pending & ifc.enable;
  assign ifc.anyReq = |live;
  assign ifc.winner = pickLowest(live);
endmodule

// >>> rtl/cis_top.sv
// interrupt and reset vectoring sequencer with avalon registers
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "cis_map.svh"
module cis_top
  import cis_pkg::*;
#(
  parameter int SRC = 8, // index 0 is external_request_zero
  parameter logic [SRC-1:0] LEVEL_MASK = '0, // ones mark level sources
  parameter int PC_W = 13,
  parameter logic [PC_W-1:0] BOOT_START = 13'h1C00, // boot section base
  parameter int VEC_STEP = 2 // words per vector slot
)
(
  input wire logic clock, // core_clock, no divider
  input wire logic rst_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [SRC-1:0] srcEvent,
  input wire logic [SRC-1:0] srcLevel,
  output logic [SRC-1:0] srcAck,
  input wire logic instrDone,
  input wire logic opSetGie,
  input wire logic opClearGie,
  input wire logic opReturn,
  input wire logic coreSleeping,
  input wire logic [PC_W-1:0] pcNow,
  input wire logic resetVectorFuse,
  input wire logic appLockBitTwo,
  input wire logic bootLockBitTwo,
  output logic busy,
  output logic pcLoad,
  output logic [PC_W-1:0] pcTarget,
  output logic stackWe,
  output logic stackRe,
  output logic [15:0] stackAddr,
  output logic [7:0] stackWdata,
  input wire logic [7:0] stackRdata,
  output logic wakeRequest
);
  localparam int IDX_W = (SRC > 1) ? $clog2(SRC) : 1;
  // all checks run on the core clock outside reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // one-hot of a source index, used for ack and checks
  function automatic logic [SRC-1:0] oneHot(input logic [IDX_W-1:0] idx);
    logic [SRC-1:0] v;
    v = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  cis_state_e state; // sequencer state
  cis_state_e next_state;
  logic [3:0] cnt; // cycle count inside a state
  logic [3:0] next_cnt;
  logic [7:0] status; // status_flags_register
  logic [SRC-1:0] enable; // per-source enables
  logic vectorTableSelect; // core_control_register bit
  logic [15:0] sp; // stack pointer
  logic [PC_W-1:0] retPc; // return address being pushed
  logic [IDX_W-1:0] winnerIdx; // latched winner
  logic sleepTaken; // accepted while asleep
  logic holdOne; // no instruction done since set or return
  logic [7:0] retHi; // popped high byte

  // request bundle shared with flags and arbiter
  cis_req_if #(.SRC(SRC)) ifc ();

  cis_flags #(.SRC(SRC), .LEVEL_MASK(LEVEL_MASK)) flags
  (
    .clock(clock),
    .rst_n(rst_n),
    .srcEvent(srcEvent),
    .srcLevel(srcLevel),
    .ifc(ifc.flags)
  );

  cis_arbiter #(.SRC(SRC)) arb
  (
    .ifc(ifc.arb)
  );

  // bus decode: first cycle answers, second cycle commits
  wire logic busReq = (read | write) & waitrequest;
  wire logic busWr = write & ~waitrequest;
  wire logic wrStatus = busWr & (address == `CIS_OFS_STATUS);
  wire logic wrEnable = busWr & (address == `CIS_OFS_ENABLE);
  wire logic wrFlags = busWr & (address == `CIS_OFS_FLAGS);
  wire logic wrControl = busWr & (address == `CIS_OFS_CONTROL);
  wire logic wrStack = busWr & (address == `CIS_OFS_STACK);

  // read mux, unmapped offsets read zero
  wire logic [31:0] rdValue =
    (address == `CIS_OFS_STATUS) ? 32'(status) :
    (address == `CIS_OFS_ENABLE) ? 32'(enable) :
    (address == `CIS_OFS_FLAGS) ? 32'(ifc.pending) :
    (address == `CIS_OFS_CONTROL) ? 32'(vectorTableSelect) :
    (address == `CIS_OFS_STACK) ? 32'(sp) :
    (address == `CIS_OFS_SEQ) ? 32'({winnerIdx, state}) : '0;

  // global enable sits in bit seven
  wire logic gie = status[`CIS_GIE_BIT];

  // boot lock suppression by where the pc runs
  wire logic pcInBoot = pcNow >= BOOT_START;
  wire logic lockSuppress =
    (appLockBitTwo & vectorTableSelect & ~pcInBoot) |
    (bootLockBitTwo & ~vectorTableSelect & pcInBoot);

  // request qualifies; a same-cycle clear kills it
  wire logic reqReady = ifc.anyReq & gie & ~opClearGie
    & ~lockSuppress;

  // only whole-instruction boundaries, or sleep once released
  wire logic boundary = instrDone
    | (coreSleeping & ~holdOne);

  // evaluated every cycle in parallel with execution
  wire logic accept = (state == CIS_IDLE) & boundary & reqReady
    & ~opSetGie & ~opReturn;

  // entry length grows when the core was asleep
  wire logic [3:0] entryLen = sleepTaken ?
    4'(`CIS_ENTRY_CYC + `CIS_WAKE_CYC) : `CIS_ENTRY_CYC;
  wire logic lastEntry = (state == CIS_ENTRY)
    & (cnt == 4'(entryLen - `CIS_CNT_ONE));
  wire logic lastJump = (state == CIS_JUMP)
    & (cnt == 4'(`CIS_JUMP_CYC - `CIS_CNT_ONE));
  wire logic lastReturn = (state == CIS_RETURN)
    & (cnt == 4'(`CIS_RETURN_CYC - `CIS_CNT_ONE));

  // stack port steps for push and pop
  wire logic pushLow = (state == CIS_ENTRY) & (cnt == '0);
  wire logic pushHigh = (state == CIS_ENTRY) & (cnt == `CIS_CNT_ONE);
  wire logic popHigh = (state == CIS_RETURN) & (cnt == '0);
  wire logic popLow = (state == CIS_RETURN) & (cnt == `CIS_CNT_ONE);
  wire logic catchHigh = (state == CIS_RETURN) & (cnt == `CIS_CNT_TWO);
  wire logic [15:0] retWide = 16'(retPc);

  // vector slot: base moves to boot start when selected
  wire logic [PC_W-1:0] vecBase = vectorTableSelect ?
    BOOT_START : '0;
  wire logic [PC_W-1:0] vecAddr = PC_W'(vecBase
    + PC_W'((winnerIdx + `CIS_CNT_ONE) * VEC_STEP));

  // reset vector from the fuse, read after release
  wire logic [PC_W-1:0] resetPc = resetVectorFuse ?
    BOOT_START : '0;

  // popped return address
  wire logic [15:0] poppedWide = {retHi, stackRdata};

  // ack strobe and flag clear at the pc redirect
  // only flag-type sources get the acknowledge
  assign ifc.ackMask = lastEntry ?
    (oneHot(winnerIdx) & ~LEVEL_MASK) : '0;
  assign ifc.clearMask = wrFlags ? writedata[SRC-1:0] : '0;
  assign ifc.enable = enable;

  // next global enable: hardware events override software
  wire logic next_gie = accept ? 1'b0 :
    opClearGie ? 1'b0 :
    (opSetGie | lastReturn) ? 1'b1 :
    wrStatus ? writedata[`CIS_GIE_BIT] : gie;

  // other status bits only change by software write
  wire logic [6:0] next_lowFlags = wrStatus ?
    writedata[6:0] : status[6:0];

  // stack pointer: push lowers, pop raises, both by two
  wire logic [15:0] next_sp =
    lastEntry ? 16'(sp - `CIS_PC_BYTES) :
    lastReturn ? 16'(sp + `CIS_PC_BYTES) :
    wrStack ? writedata[15:0] : sp;

  wire logic [15:0] next_stackAddr =
    pushLow ? sp :
    pushHigh ? 16'(sp - `CIS_SP_STEP) :
    popHigh ? 16'(sp + `CIS_SP_STEP) :
    popLow ? 16'(sp + `CIS_PC_BYTES) : stackAddr;

  wire logic [PC_W-1:0] next_pcTarget =
    (state == CIS_RSTV) ? resetPc :
    lastEntry ? vecAddr :
    lastReturn ? poppedWide[PC_W-1:0] : pcTarget;

  // state machine
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      CIS_RSTV:
      begin
        next_state = CIS_IDLE; // reset vector issued
      end
      CIS_IDLE:
      begin
        next_cnt = '0;
        if (accept)
          next_state = CIS_ENTRY;
        else if (opReturn)
          next_state = CIS_RETURN;
      end
      CIS_ENTRY:
      begin
        next_cnt = 4'(cnt + `CIS_CNT_ONE);
        if (lastEntry)
        begin
          next_state = CIS_JUMP;
          next_cnt = '0;
        end
      end
      CIS_JUMP:
      begin
        next_cnt = 4'(cnt + `CIS_CNT_ONE);
        if (lastJump)
          next_state = CIS_IDLE;
      end
      CIS_RETURN:
      begin
        next_cnt = 4'(cnt + `CIS_CNT_ONE);
        if (lastReturn)
          next_state = CIS_IDLE;
      end
      default:
      begin
        next_state = CIS_IDLE;
        next_cnt = '0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state <= CIS_RSTV;
      cnt <= '0;
      holdOne <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      holdOne <= (opSetGie | lastReturn) | (holdOne & ~instrDone);
    end
  end

  // entry context latched at acceptance, popped high byte caught during return
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      retPc <= '0;
      winnerIdx <= '0;
      sleepTaken <= 1'b0;
      retHi <= 8'h00;
    end
    else
    begin
      if (accept)
      begin
        retPc <= pcNow;
        winnerIdx <= ifc.winner;
        sleepTaken <= coreSleeping;
      end
      if (catchHigh)
        retHi <= stackRdata;
    end
  end

  // software visible registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      status <= `CIS_STATUS_RST;
      enable <= '0;
      vectorTableSelect <= 1'b0;
      sp <= `CIS_SP_RST;
    end
    else
    begin
      status <= {next_gie, next_lowFlags};
      sp <= next_sp;
      if (wrEnable)
        enable <= writedata[SRC-1:0];
      if (wrControl)
        vectorTableSelect <= writedata[`CIS_VTS_BIT];
    end
  end

  // avalon answer: waitrequest drops one cycle after request
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      waitrequest <= 1'b1;
      readdata <= '0;
    end
    else
    begin
      waitrequest <= ~busReq;
      if (busReq & read)
        readdata <= rdValue;
    end
  end

  // registered outputs toward the pipeline and stack
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      busy <= 1'b1;
      pcLoad <= 1'b0;
      pcTarget <= '0;
      srcAck <= '0;
      stackWe <= 1'b0;
      stackRe <= 1'b0;
      stackAddr <= `CIS_SP_RST;
      stackWdata <= 8'h00;
      wakeRequest <= 1'b0;
    end
    else
    begin
      busy <= next_state != CIS_IDLE;
      pcLoad <= (state == CIS_RSTV) | lastEntry | lastReturn;
      pcTarget <= next_pcTarget;
      srcAck <= ifc.ackMask;
      stackWe <= pushLow | pushHigh;
      stackRe <= popHigh | popLow;
      stackAddr <= next_stackAddr;
      stackWdata <= pushLow ? retWide[7:0] : retWide[15:8];
      wakeRequest <= coreSleeping & reqReady;
    end
  end

  // checks
  wire logic [SRC-1:0] evtFlag = srcEvent & ~LEVEL_MASK;
  wire logic [SRC-1:0] liveReq = ifc.pending & enable;

  a_gie_gate_take: assert property (
    accept |-> gie && liveReq != '0)
    else $error("accepted without enables");
  a_lowest_wins: assert property (
    accept |-> (liveReq & SRC'(oneHot(ifc.winner) - 1'b1)) == '0)
    else $error("higher priority request skipped");
  a_entry_clears_gie: assert property (
    accept |=> !gie ##1 stackWe)
    else $error("entry did not clear enable then push");
  a_cli_blocks_take: assert property (
    opClearGie |-> !accept)
    else $error("accepted alongside clear enable");
  a_entry_four_cycles: assert property (
    accept && !coreSleeping |=> (state == CIS_ENTRY)[*4]
      ##1 (state == CIS_JUMP && pcLoad))
    else $error("awake entry not four cycles");
  a_wake_entry_eight: assert property (
    accept && coreSleeping |=> (state == CIS_ENTRY)[*8]
      ##1 state == CIS_JUMP)
    else $error("sleep entry not eight cycles");
  a_jump_three: assert property (
    state == CIS_ENTRY ##1 state == CIS_JUMP |->
      (state == CIS_JUMP)[*3] ##1 state == CIS_IDLE)
    else $error("jump phase not three cycles");
  a_return_four: assert property (
    state == CIS_IDLE && opReturn |=> (state == CIS_RETURN)[*4]
      ##1 (pcLoad && gie && !busy))
    else $error("return not four cycles");
  a_ack_on_redirect: assert property (
    srcAck != '0 |-> pcLoad && $onehot(srcAck))
    else $error("ack without pc redirect");
  a_sp_push_two: assert property (
    accept && !coreSleeping && !write |=> ##4
      sp == 16'($past(sp, 5) - `CIS_PC_BYTES))
    else $error("push did not lower sp by two");
  a_status_kept: assert property (
    state == CIS_ENTRY && !wrStatus |=> status[6:0] == $past(status[6:0]))
    else $error("status flags touched on entry");
  a_event_flagged: assert property (
    evtFlag != '0 |=> (ifc.pending & $past(evtFlag)) == $past(evtFlag))
    else $error("event flag lost");
  c_wake_take: cover property (accept && coreSleeping);
  c_return_done: cover property (lastReturn);
  c_nested_take: cover property (state == CIS_JUMP ##[1:40] accept);
endmodule

// >>> dv/cis_stack_model.sv
// behavioural stack memory on the far side of the sequencer
`timescale 1ns/10ps
module cis_stack_model
(
  input wire logic clock,
  input wire logic stackWe,
  input wire logic stackRe,
  input wire logic [15:0] stackAddr,
  input wire logic [7:0] stackWdata,
  output logic [7:0] stackRdata
);
  // byte storage over the whole stack space
  logic [7:0] mem [0:65535];
  // defined start so the toggling idle pattern is never unknown
  initial
  begin
    stackRdata = 8'h00;
  end
  // one-cycle read latency, idle data toggles so stale bytes never pass
  always @(posedge clock)
  begin
    if (stackWe)
      mem[stackAddr] <= stackWdata;
    if (stackRe)
      stackRdata <= mem[stackAddr];
    else
      stackRdata <= ~stackRdata;
  end
endmodule

// >>> dv/test_cpu_interrupt_sequencer.sv
// self-checking bench for the interrupt sequencer
`timescale 1ns/10ps
module test_cpu_interrupt_sequencer;
  localparam logic [12:0] BOOT = 13'h1C00; // boot section base
  logic clock = 1'b0; // 50 MHz core clock
  logic rst_n, read, write, waitrequest, busy, pcLoad;
  logic instrDone, opSetGie, opClearGie, opReturn, coreSleeping;
  logic resetVectorFuse, stackWe, stackRe, wakeRequest;
  logic appLockBitTwo, bootLockBitTwo; // lock bit straps
  logic [7:0] address, srcEvent, srcLevel, srcAck;
  logic [7:0] stackRdata, stackWdata;
  logic [31:0] writedata, readdata;
  logic [12:0] pcNow, pcTarget;
  logic [15:0] stackAddr, spNow; // spNow: expected stack pointer
  int miscompares = 0;
  int checkCount = 0;

  // clock, 20 ns period
  always #10 clock = ~clock;

  cis_top #(.LEVEL_MASK(8'h80), .BOOT_START(BOOT)) uut (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .srcEvent(srcEvent),
    .srcLevel(srcLevel), .srcAck(srcAck), .instrDone(instrDone),
    .opSetGie(opSetGie), .opClearGie(opClearGie),
    .opReturn(opReturn), .coreSleeping(coreSleeping), .pcNow(pcNow),
    .resetVectorFuse(resetVectorFuse), .appLockBitTwo(appLockBitTwo),
    .bootLockBitTwo(bootLockBitTwo), .busy(busy), .pcLoad(pcLoad),
    .pcTarget(pcTarget), .stackWe(stackWe), .stackRe(stackRe),
    .stackAddr(stackAddr), .stackWdata(stackWdata),
    .stackRdata(stackRdata), .wakeRequest(wakeRequest));

  cis_stack_model stack (
    .clock(clock), .stackWe(stackWe), .stackRe(stackRe),
    .stackAddr(stackAddr), .stackWdata(stackWdata),
    .stackRdata(stackRdata));

  // verdict and end of run
  task completeRun;
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one comparison, reported at once
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // a wait limit ran out
  task tmo;
    miscompares++;
    $display("ERROR %0t: wait limit reached", $time);
    completeRun();
  endtask

  // avalon access, held until waitrequest is sampled low
  task bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clock);
    address <= a;
    read <= rd;
    write <= ~rd;
    writedata <= d;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0)
      tmo();
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // register read with expected word
  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  // register write
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask

  // one-cycle event pulse on flag sources
  task ev(input logic [7:0] v);
    @(posedge clock);
    srcEvent <= v;
    @(posedge clock);
    srcEvent <= 8'h00;
  endtask

  // no sequence may start for n cycles
  task quiet(input int n);
    repeat (n)
    begin
      @(posedge clock);
      chk(busy, 1'b0);
    end
  endtask

  // reset with a fuse setting, then the reset vector load
  task rstc(input logic f);
    int k;
    @(posedge clock);
    rst_n <= 1'b0;
    resetVectorFuse <= f;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (pcLoad !== 1'b1 && k < 8);
    chk(k, 2);
    chk(pcTarget, f ? BOOT : 13'h0000);
  endtask

  // kind 0 boundary entry, 1 entry from sleep by level, 2 return
  task seq(input int kind, input logic [12:0] tgt,
    input logic [7:0] ack, input int lat);
    int k;
    int nw;
    int nwk;
    logic [15:0] wa [2];
    logic [7:0] wd [2];
    @(posedge clock);
    instrDone <= (kind == 0);
    coreSleeping <= (kind == 1);
    srcLevel[7] <= (kind == 1);
    opReturn <= (kind == 2);
    k = 0;
    nw = 0;
    nwk = 0;
    do
    begin
      @(posedge clock);
      instrDone <= 1'b0;
      opReturn <= 1'b0;
      k++;
      // capture the return address pushes
      if (stackWe === 1'b1 && nw < 2)
      begin
        wa[nw] = stackAddr;
        wd[nw] = stackWdata;
        nw++;
      end
      // count wake request cycles
      if (wakeRequest === 1'b1)
        nwk++;
    end
    while (pcLoad !== 1'b1 && k < 20);
    chk(k, lat);
    chk(pcTarget, tgt);
    chk(srcAck, ack);
    chk(nwk, (kind == 1) ? 1 : 0);
    if (kind == 2)
      spNow = spNow + 16'h0002;
    else
    begin
      chk(nw, 2);
      chk(wa[0], spNow);
      chk(wd[0], pcNow[7:0]);
      chk(wa[1], spNow - 16'h0001);
      chk(wd[1], {3'b000, pcNow[12:8]});
      spNow = spNow - 16'h0002;
    end
    coreSleeping <= 1'b0;
    srcLevel <= 8'h00;
    k = 0;
    while (busy !== 1'b0 && k < 20)
    begin
      @(posedge clock);
      k++;
    end
    if (busy !== 1'b0)
      tmo();
  endtask

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    srcEvent = 8'h00;
    srcLevel = 8'h00;
    instrDone = 1'b0;
    opSetGie = 1'b0;
    opClearGie = 1'b0;
    opReturn = 1'b0;
    coreSleeping = 1'b0;
    resetVectorFuse = 1'b0;
    appLockBitTwo = 1'b0;
    bootLockBitTwo = 1'b0;
    pcNow = 13'h0ABC;
    spNow = 16'h0100;
    rstc(1'b1);
    rstc(1'b0);
    // reset values and an unmapped place
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    wr(8'h10, 32'h0000_0100);
    wr(8'h04, 32'h0000_0085);
    wr(8'h00, 32'h0000_002A);
    // flags raised while masked stay pending, one clears
    ev(8'h0D);
    rd(8'h08, 32'h0000_000D);
    wr(8'h08, 32'h0000_0008);
    rd(8'h08, 32'h0000_0005);
    // boundary in the same cycle as the set is not taken
    @(posedge clock);
    opSetGie <= 1'b1;
    instrDone <= 1'b1;
    @(posedge clock);
    opSetGie <= 1'b0;
    instrDone <= 1'b0;
    quiet(4);
    seq(0, 13'h0002, 8'h01, 6);
    rd(8'h00, 32'h0000_002A);
    rd(8'h10, 32'h0000_00FE);
    rd(8'h08, 32'h0000_0004);
    seq(2, 13'h0ABC, 8'h00, 6);
    rd(8'h00, 32'h0000_00AA);
    rd(8'h10, 32'h0000_0100);
    quiet(4);
    pcNow <= 13'h1555;
    seq(0, 13'h0006, 8'h04, 6);
    rd(8'h14, 32'h0000_0011);
    seq(2, 13'h1555, 8'h00, 6);
    // clear in the same cycle as a boundary blocks entry
    ev(8'h01);
    @(posedge clock);
    opClearGie <= 1'b1;
    instrDone <= 1'b1;
    @(posedge clock);
    opClearGie <= 1'b0;
    instrDone <= 1'b0;
    quiet(4);
    rd(8'h00, 32'h0000_002A);
    // vectors moved to the boot section
    wr(8'h0C, 32'h0000_0001);
    @(posedge clock);
    opSetGie <= 1'b1;
    @(posedge clock);
    opSetGie <= 1'b0;
    seq(0, BOOT + 13'h0002, 8'h01, 6);
    seq(2, 13'h1555, 8'h00, 6);
    // app lock holds requests off while application code runs
    appLockBitTwo <= 1'b1;
    ev(8'h01);
    @(posedge clock);
    instrDone <= 1'b1;
    @(posedge clock);
    instrDone <= 1'b0;
    quiet(4);
    rd(8'h08, 32'h0000_0001);
    // boot lock alone does not block with vectors in boot
    appLockBitTwo <= 1'b0;
    bootLockBitTwo <= 1'b1;
    seq(0, BOOT + 13'h0002, 8'h01, 6);
    seq(2, 13'h1555, 8'h00, 6);
    bootLockBitTwo <= 1'b0;
    @(posedge clock);
    instrDone <= 1'b1;
    @(posedge clock);
    instrDone <= 1'b0;
    // level source wakes the sleeping core
    seq(1, BOOT + 13'h0010, 8'h00, 10);
    rd(8'h08, 32'h0000_0000);
    completeRun();
  end
endmodule
